/* File: bench/war_mem_model.sv */
// Element memory with one-cycle reads and stallable writes
`timescale 1ns/10ps
module war_mem_model (
	input wire logic        clk_sys,
	input wire logic        stallOn,
	input wire logic        memRdEn,
	input wire logic [15:0] memRdAddr,
	output logic     [15:0] memRdData,
	input wire logic        memWrEn,
	input wire logic [15:0] memWrAddr,
	input wire logic [15:0] memWrData,
	output logic            memWrReady
);
	logic [15:0] memArr [0:127];
	int          stallSeed = 32'h0000_5a17;

	initial begin
		memRdData = 16'h0000;
		memWrReady = 1'b1;
	end

	always @(posedge clk_sys) begin
		if (memRdEn)
			memRdData <= memArr[memRdAddr[6:0]];
		else
			memRdData <= ~memRdData; // Stale data never looks valid
		if (memWrEn && memWrReady)
			memArr[memWrAddr[6:0]] <= memWrData;
		memWrReady <= !stallOn || ($random(stallSeed) & 3) == 0;
	end
endmodule // war_mem_model

/* File: bench/war_reshape_unit_sva.sv */
// Port-level checks for the reshape unit
`timescale 1ns/10ps
module war_reshape_unit_sva (
	input wire logic        clk_sys,
	input wire logic        sys_rst,
	input wire logic        enableCondition,
	input wire logic [2:0]  opSelect,
	input wire logic [15:0] sourceStart,
	input wire logic [15:0] destStart,
	input wire logic [15:0] elementCount,
	input wire logic        busy,
	input wire logic        opDone,
	input wire logic        memRdEn,
	input wire logic [15:0] memRdAddr,
	input wire logic [15:0] memRdData,
	input wire logic        memWrEn,
	input wire logic [15:0] memWrAddr,
	input wire logic [15:0] memWrData,
	input wire logic        memWrReady
);
	logic        take;
	logic        nullTake;
	logic        meanOk;
	logic        smallCnt;
	logic [2:0]  opReg;
	logic [15:0] rdAddrReg;
	logic [15:0] wrAddrReg;
	logic [15:0] wrCountReg;
	logic [15:0] wantReg;
	logic [15:0] wantNext;

	assign take = enableCondition && !busy;
	assign meanOk = elementCount != 16'h0000 && elementCount <= 16'h0040;
	assign smallCnt = elementCount != 16'h0000 && elementCount <= 16'h0004;
	assign nullTake = take && wantNext == 16'h0000;

	// Writes an operation must make, counted from its inputs at take
	always_comb begin
		case (opSelect)
			3'h0: wantNext = {15'h0000, meanOk};
			3'h1: wantNext = elementCount;
			3'h2: wantNext = (elementCount >> 1) + {15'h0000, elementCount[0]};
			3'h3: wantNext = {15'h0000, smallCnt};
			3'h4: wantNext = smallCnt ? elementCount : 16'h0000;
			default: wantNext = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			opReg <= 3'h0;
			rdAddrReg <= 16'h0000;
			wrAddrReg <= 16'h0000;
			wrCountReg <= 16'h0000;
			wantReg <= 16'h0000;
		end else if (take) begin
			opReg <= opSelect;
			rdAddrReg <= sourceStart;
			wrAddrReg <= destStart;
			wrCountReg <= 16'h0000;
			wantReg <= wantNext;
		end else begin
			if (memRdEn)
				rdAddrReg <= rdAddrReg + 16'h0001;
			if (memWrEn && memWrReady) begin
				wrAddrReg <= wrAddrReg + 16'h0001;
				wrCountReg <= wrCountReg + 16'h0001;
			end
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	sequence sNullTake;
		nullTake;
	endsequence
	sequence sQuiet;
		(!memRdEn && !memWrEn) [*3];
	endsequence
	sequence sStall;
		memWrEn && !memWrReady;
	endsequence

	a_done_one_pulse: assert property (opDone |=> !opDone)
		else $error("done pulse longer than one cycle");
	a_take_sets_busy: assert property (take |=> busy)
		else $error("start not taken");
	a_wr_held_stable: assert property (sStall |=> memWrEn
		&& $stable(memWrAddr) && $stable(memWrData))
		else $error("stalled write changed");
	a_rd_addr_order: assert property (memRdEn
		|-> memRdAddr == rdAddrReg)
		else $error("read address out of sequence");
	a_wr_addr_order: assert property (memWrEn
		|-> memWrAddr == wrAddrReg)
		else $error("write address out of sequence");
	a_split_hi_zero: assert property (memWrEn && opReg == 3'h1
		|-> memWrData[15:8] == 8'h00)
		else $error("split high byte not clear");
	a_nib_upper_zero: assert property (memWrEn && opReg == 3'h4
		|-> memWrData[15:4] == 12'h000)
		else $error("nibble upper bits not clear");
	a_write_count: assert property (opDone |-> wrCountReg == wantReg)
		else $error("wrong number of writes");
	a_null_quiet: assert property (sNullTake |=> sQuiet)
		else $error("memory touched by empty operation");
	a_null_done_soon: assert property (sNullTake |-> ##[1:3] opDone)
		else $error("empty operation not finished");
endmodule // war_reshape_unit_sva

bind war_reshape_unit war_reshape_unit_sva chk (
	.clk_sys(clk_sys), .sys_rst(sys_rst),
	.enableCondition(enableCondition), .opSelect(opSelect),
	.sourceStart(sourceStart), .destStart(destStart),
	.elementCount(elementCount), .busy(busy), .opDone(opDone),
	.memRdEn(memRdEn), .memRdAddr(memRdAddr), .memRdData(memRdData),
	.memWrEn(memWrEn), .memWrAddr(memWrAddr), .memWrData(memWrData),
	.memWrReady(memWrReady)
);

/* File: bench/war_reshape_unit_tb.sv */
// Self-checking bench for the word array reshape unit
`timescale 1ns/10ps
module war_reshape_unit_tb;
	logic        clk_sys;
	logic        sys_rst;
	logic        enableCondition;
	logic [2:0]  opSelect;
	logic [15:0] sourceStart;
	logic [15:0] destStart;
	logic [15:0] elementCount;
	logic        busy;
	logic        opDone;
	logic        memRdEn;
	logic [15:0] memRdAddr;
	logic [15:0] memRdData;
	logic        memWrEn;
	logic [15:0] memWrAddr;
	logic [15:0] memWrData;
	logic        memWrReady;
	logic        stallOn;
	logic [15:0] expMem [0:127];
	logic [31:0] r;
	int          n;
	int          mismatches = 0;
	int          check_count = 0;
	int          seed = 32'h2017b059;
	int          cycles = 0;

	war_reshape_unit uut (
		.clk_sys(clk_sys), .sys_rst(sys_rst),
		.enableCondition(enableCondition), .opSelect(opSelect),
		.sourceStart(sourceStart), .destStart(destStart),
		.elementCount(elementCount), .busy(busy), .opDone(opDone),
		.memRdEn(memRdEn), .memRdAddr(memRdAddr), .memRdData(memRdData),
		.memWrEn(memWrEn), .memWrAddr(memWrAddr), .memWrData(memWrData),
		.memWrReady(memWrReady)
	);
	war_mem_model mem (
		.clk_sys(clk_sys), .stallOn(stallOn),
		.memRdEn(memRdEn), .memRdAddr(memRdAddr), .memRdData(memRdData),
		.memWrEn(memWrEn), .memWrAddr(memWrAddr), .memWrData(memWrData),
		.memWrReady(memWrReady)
	);

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task automatic results();
		if (mismatches == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			mismatches++;
			results();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		check_count++;
		if (seen !== want) begin
			mismatches++;
			$display("wrong value at %0t: seen %h want %h", $time, seen, want);
		end
	endtask

	function automatic void expect_op(logic [2:0] op, int src, dst, cnt);
		int          sum;
		int          q;
		logic [15:0] w;
		logic [15:0] v;
		case (op)
			3'h0: if (cnt >= 1 && cnt <= 64) begin
				sum = 0;
				for (int i = 0; i < cnt; i++)
					sum += $signed(expMem[src + i]);
				q = sum / cnt;
				if (sum < 0 && sum % cnt != 0)
					q--;
				expMem[dst] = q[15:0];
			end
			3'h1: for (int i = 0; i < cnt; i++) begin
				w = expMem[src + i / 2];
				v = {8'h00, i % 2 ? w[7:0] : w[15:8]};
				expMem[dst + i] = v;
			end
			3'h2: for (int i = 0; 2 * i < cnt; i++) begin
				v = {expMem[src + 2 * i][7:0], 8'h00};
				if (2 * i + 1 < cnt)
					v[7:0] = expMem[src + 2 * i + 1][7:0];
				expMem[dst + i] = v;
			end
			3'h3: if (cnt >= 1 && cnt <= 4) begin
				v = 16'h0000;
				for (int i = 0; i < cnt; i++)
					v[15 - 4 * i -: 4] = expMem[src + i][3:0];
				expMem[dst] = v;
			end
			3'h4: if (cnt >= 1 && cnt <= 4) begin
				w = expMem[src];
				for (int i = 0; i < cnt; i++)
					expMem[dst + i] = {12'h000, w[15 - 4 * i -: 4]};
			end
			default: ;
		endcase
	endfunction

	task automatic put(input int a, input logic [15:0] v);
		expMem[a] = v;
		mem.memArr[a] = v;
	endtask

	// One start pulse, garbage fields after take, one refused start after the first read
	task automatic run(input logic [2:0] op, input int src, dst, cnt);
		logic poke;
		logic poked;
		int   k;
		poked = 1'b0;
		@(posedge clk_sys);
		opSelect <= op;
		sourceStart <= src[15:0];
		destStart <= dst[15:0];
		elementCount <= cnt[15:0];
		enableCondition <= 1'b1;
		@(posedge clk_sys);
		enableCondition <= 1'b0;
		{opSelect, sourceStart, destStart} <=
			35'({$random(seed), $random(seed)});
		elementCount <= 16'($random(seed));
		expect_op(op, src, dst, cnt);
		#1;
		k = 0;
		while (opDone !== 1'b1 && k < 3000) begin
			poke = memRdEn === 1'b1 && !poked;
			poked = poked || poke;
			@(posedge clk_sys);
			enableCondition <= poke;
			#1;
			k++;
		end
		check({15'h0000, opDone}, 16'h0001);
		@(posedge clk_sys);
		enableCondition <= 1'b0;
		#1;
		check({14'h0000, busy, opDone}, 16'h0000);
		for (int i = 0; i < 128; i++)
			check(mem.memArr[i], expMem[i]);
	endtask

	initial begin
		sys_rst = 1'b1;
		enableCondition = 1'b0;
		opSelect = 3'h0;
		sourceStart = 16'h0000;
		destStart = 16'h0000;
		elementCount = 16'h0000;
		stallOn = 1'b0;
		for (int i = 0; i < 128; i++)
			put(i, 16'($random(seed)));
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		put(0, 16'h0020);
		put(1, 16'h000a);
		put(2, 16'h000f);
		put(3, 16'hfff2);
		put(4, 16'hfffb);
		put(5, 16'h0102);
		put(6, 16'h0304);
		put(7, 16'h0506);
		for (int i = 0; i < 6; i++)
			put(8 + i, 16'h0001 + 16'(i));
		put(14, 16'h1234);
		run(3'h0, 0, 64, 4);
		run(3'h0, 3, 65, 2);
		run(3'h0, 0, 66, 64);
		run(3'h0, 0, 67, 65);
		run(3'h0, 0, 68, 0);
		for (int c = 0; c < 7; c++) begin
			run(3'h1, 5, 64, c);
			run(3'h2, 8, 80, c);
			run(3'h3, 8, 96, c);
			run(3'h4, 14, 112, c);
		end
		for (int op = 5; op < 8; op++)
			run(op[2:0], 8, 64, 4);
		stallOn = 1'b1;
		run(3'h1, 0, 64, 60);
		for (int k = 0; k < 50; k++) begin
			r = $random(seed);
			stallOn = r[20];
			if (k % 10 == 0)
				for (int i = 0; i < 128; i++)
					put(i, 16'($random(seed)));
			case (r[2:0])
				3'h0: n = r[14:8] % 66;
				3'h1, 3'h2: n = r[13:8] % 61;
				default: n = r[10:8] % 6;
			endcase
			run(r[2:0], r[17:16], 64 + r[19:18], n);
		end
		results();
	end
endmodule // war_reshape_unit_tb

/* File: shared/war_pkg.sv */
// Shared constants and types for the word array reshape unit
package war_pkg;

	localparam int DATA_W     = 16;
	localparam int ADDR_W     = 16;
	localparam int CNT_W      = 16;
	localparam int OP_W       = 3;
	localparam int BYTE_W     = 8;
	localparam int NIB_W      = 4;
	localparam int MEAN_CNT_W = 7;
	localparam int SUM_W      = 22;
	localparam int DIV_STEP_W = 5;
	localparam int FIFO_DEPTH = 8;
	localparam int FIFO_LVL_W = 4;

	localparam logic [CNT_W-1:0]      MEAN_MAX_COUNT = 16'h0040;
	localparam logic [CNT_W-1:0]      NIB_MAX_COUNT  = 16'h0004;
	localparam logic [2:0]            NIB_PER_WORD   = 3'h4;
	localparam logic [DIV_STEP_W-1:0] DIV_STEPS      = 5'h16;
	localparam logic [BYTE_W-1:0]     BYTE_ZERO      = 8'h00;
	localparam logic [11:0]           NIB_PAD_ZERO   = 12'h000;
	localparam logic [SUM_W-1:0]      SUM_RESET      = 22'h000000;
	localparam logic [11:0]           PACK_RESET     = 12'h000;

	typedef enum logic [OP_W-1:0] {
		OP_MEAN                = 3'h0,
		OP_WORD_TO_BYTE_SPLIT  = 3'h1,
		OP_BYTE_TO_WORD_COMBINE = 3'h2,
		OP_NIBBLE_PACK         = 3'h3,
		OP_NIBBLE_SPLIT        = 3'h4
	} war_op_t;

endpackage

/* File: src/war_divider.sv */
// Unsigned restoring divider, one quotient bit per cycle
`timescale 1ns/10ps
module war_divider (
	input  wire logic                             clk_sys,
	input  wire logic                             sys_rst,
	input  wire logic                             start,
	input  wire logic [war_pkg::SUM_W-1:0]        dividend,
	input  wire logic [war_pkg::MEAN_CNT_W-1:0]   divisor,
	output logic                                  done,
	output logic [war_pkg::SUM_W-1:0]             quotient,
	output logic [war_pkg::MEAN_CNT_W-1:0]        remainder
);
	typedef struct packed {
		logic                              busy;
		logic [war_pkg::DIV_STEP_W-1:0]    steps;
		logic [war_pkg::SUM_W-1:0]         quot;
		logic [war_pkg::MEAN_CNT_W:0]      rem;
		logic [war_pkg::MEAN_CNT_W-1:0]    dvsr;
		logic                              done;
	} war_div_state_t;

	war_div_state_t s_reg;
	war_div_state_t s_next;
	logic [war_pkg::MEAN_CNT_W:0] trial;

	assign done      = s_reg.done;
	assign quotient  = s_reg.quot;
	assign remainder = s_reg.rem[war_pkg::MEAN_CNT_W-1:0];

	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		trial = {s_reg.rem[war_pkg::MEAN_CNT_W-1:0],
			s_reg.quot[war_pkg::SUM_W-1]};
		if (start) begin
			s_next.busy  = 1'b1;
			s_next.steps = war_pkg::DIV_STEPS;
			s_next.quot  = dividend;
			s_next.rem   = '0;
			s_next.dvsr  = divisor;
		end else if (s_reg.busy) begin
			s_next.quot = {s_reg.quot[war_pkg::SUM_W-2:0], 1'b0};
			if (trial >= {1'b0, s_reg.dvsr}) begin
				s_next.rem     = trial - {1'b0, s_reg.dvsr};
				s_next.quot[0] = 1'b1;
			end else begin
				s_next.rem = trial;
			end
			s_next.steps = s_reg.steps - war_pkg::DIV_STEP_W'(1);
			if (s_reg.steps == war_pkg::DIV_STEP_W'(1)) begin
				s_next.busy = 1'b0;
				s_next.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule // war_divider

/* File: src/war_fifo.sv */
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/10ps
module war_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input  wire logic                         clk_sys,
	input  wire logic                         sys_rst,
	input  wire logic                         inValid,
	output logic                              inReady,
	input  wire logic [WIDTH-1:0]             inData,
	output logic                              outValid,
	input  wire logic                         outReady,
	output logic [WIDTH-1:0]                  outData,
	output logic [$clog2(DEPTH+1)-1:0]        level
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int LVL_W = $clog2(DEPTH+1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PTR_W-1:0]            wrPtr;
		logic [PTR_W-1:0]            rdPtr;
		logic [LVL_W-1:0]            count;
	} war_fifo_state_t;

	war_fifo_state_t s_reg;
	war_fifo_state_t s_next;
	logic            doPush;
	logic            doPop;

	assign inReady  = (s_reg.count != LVL_W'(DEPTH));
	assign outValid = (s_reg.count != '0);
	assign outData  = s_reg.mem[s_reg.rdPtr];
	assign level    = s_reg.count;
	assign doPush   = inValid && inReady;
	assign doPop    = outValid && outReady;

	always_comb begin
		s_next = s_reg;
		if (doPush) begin
			s_next.mem[s_reg.wrPtr] = inData;
			s_next.wrPtr = (s_reg.wrPtr == PTR_W'(DEPTH - 1)) ? '0 :
				s_reg.wrPtr + PTR_W'(1);
		end
		if (doPop) begin
			s_next.rdPtr = (s_reg.rdPtr == PTR_W'(DEPTH - 1)) ? '0 :
				s_reg.rdPtr + PTR_W'(1);
		end
		if (doPush && !doPop) begin
			s_next.count = s_reg.count + LVL_W'(1);
		end else if (doPop && !doPush) begin
			s_next.count = s_reg.count - LVL_W'(1);
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule // war_fifo

/* File: src/war_reshape_unit.sv */
// Word array reshape unit: mean, byte and nibble reshaping over memory
// Notes on behaviour
// - Mean sums count consecutive words, writes sum over count.
// - Mean result rounds down; remainder is dropped.
// - Operation starts on enable with given source, destination, count.
// - Byte split puts each byte in low byte, clears high byte.
// - Byte split emits source high byte before its low byte.
// - Odd byte split count uses only high byte of last source word.
// - Byte split and combine with zero count do no reads or writes.
// - Byte combine packs source low bytes two per destination word.
// - Byte combine puts earlier byte high, later byte low.
// - Odd byte combine count clears final destination low byte.
// - Nibble pack packs low nibbles into one word, first on top.
// - Nibble pack with count 1 to 3 zeroes the unused low nibbles.
// - Nibble pack count zero leaves destination untouched.
// - Nibble split count zero does no processing, no writes.
// - Nibble split writes nibbles, top first, to successive words.
// - Nibble split results hold only the nibble, upper bits zero.
// - Nibble split runs only for counts one to four.
`timescale 1ns/10ps
module war_reshape_unit (
	input  wire logic                            clk_sys,
	input  wire logic                            sys_rst,
	input  wire logic                            enableCondition,
	input  wire logic [war_pkg::OP_W-1:0]        opSelect,
	input  wire logic [war_pkg::ADDR_W-1:0]      sourceStart,
	input  wire logic [war_pkg::ADDR_W-1:0]      destStart,
	input  wire logic [war_pkg::CNT_W-1:0]       elementCount,
	output logic                                 busy,
	output logic                                 opDone,
	output logic                                 memRdEn,
	output logic [war_pkg::ADDR_W-1:0]           memRdAddr,
	input  wire logic [war_pkg::DATA_W-1:0]      memRdData,
	output logic                                 memWrEn,
	output logic [war_pkg::ADDR_W-1:0]           memWrAddr,
	output logic [war_pkg::DATA_W-1:0]           memWrData,
	input  wire logic                            memWrReady
);
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_RUN    = 2'b01,
		ST_DIV    = 2'b10,
		ST_FINISH = 2'b11
	} war_state_t;

	typedef struct packed {
		war_state_t                       st;
		war_pkg::war_op_t                 op;
		logic [war_pkg::ADDR_W-1:0]       rdAddr;
		logic [war_pkg::CNT_W-1:0]        rdLeft;
		logic [war_pkg::ADDR_W-1:0]       wrAddr;
		logic [war_pkg::CNT_W-1:0]        outLeft;
		logic [2:0]                       packCnt;
		logic [war_pkg::MEAN_CNT_W-1:0]   meanCnt;
		logic                             rdPending;
		logic [war_pkg::DATA_W-1:0]       holdWord;
		logic                             holdValid;
		logic                             phase;
		logic [war_pkg::BYTE_W-1:0]       byteHi;
		logic [11:0]                      packAcc;
		logic [war_pkg::SUM_W-1:0]        sum;
		logic                             divStart;
		logic                             memRdEn;
		logic [war_pkg::ADDR_W-1:0]       memRdAddr;
		logic                             memWrEn;
		logic [war_pkg::ADDR_W-1:0]       memWrAddr;
		logic [war_pkg::DATA_W-1:0]       memWrData;
		logic                             opDone;
	} war_ctrl_t;

	war_ctrl_t s_reg;
	war_ctrl_t s_next;

	logic                              fifoInReady;
	logic                              fifoOutValid;
	logic                              fifoPop;
	logic [war_pkg::DATA_W-1:0]        fifoOutData;
	logic [war_pkg::FIFO_LVL_W-1:0]    fifoLevel;
	logic [war_pkg::FIFO_LVL_W:0]      committed;
	logic                              roomOk;
	logic                              wrFree;
	logic [war_pkg::CNT_W-1:0]         planReads;
	logic [war_pkg::CNT_W-1:0]         planOuts;
	logic [war_pkg::CNT_W:0]           halfUp;
	logic                              divDone;
	logic [war_pkg::SUM_W-1:0]         divQuot;
	logic [war_pkg::MEAN_CNT_W-1:0]    divRem;
	logic [war_pkg::SUM_W-1:0]         sumMag;
	logic                              sumNeg;
	logic [war_pkg::SUM_W-1:0]         floorQuot;
	logic [war_pkg::SUM_W-1:0]         meanResult;
	logic [war_pkg::DATA_W-1:0]        packWord;
	logic [3:0]                        packShift;

	assign busy      = (s_reg.st != ST_IDLE);
	assign opDone    = s_reg.opDone;
	assign memRdEn   = s_reg.memRdEn;
	assign memRdAddr = s_reg.memRdAddr;
	assign memWrEn   = s_reg.memWrEn;
	assign memWrAddr = s_reg.memWrAddr;
	assign memWrData = s_reg.memWrData;

	// A held write blocks new results until memory takes it
	assign wrFree = !s_reg.memWrEn || memWrReady;

	// Reads in flight are counted so returning data always finds room
	assign committed = {1'b0, fifoLevel}
		+ (war_pkg::FIFO_LVL_W+1)'(s_reg.memRdEn)
		+ (war_pkg::FIFO_LVL_W+1)'(s_reg.rdPending);
	assign roomOk = fifoInReady
		&& (committed < (war_pkg::FIFO_LVL_W+1)'(war_pkg::FIFO_DEPTH));

	war_fifo #(
		.WIDTH (war_pkg::DATA_W),
		.DEPTH (war_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys  (clk_sys),
		.sys_rst  (sys_rst),
		.inValid  (s_reg.rdPending),
		.inReady  (fifoInReady),
		.inData   (memRdData),
		.outValid (fifoOutValid),
		.outReady (fifoPop),
		.outData  (fifoOutData),
		.level    (fifoLevel)
	);

	// Signed sum handled as magnitude; sign restored with floor below
	assign sumNeg = s_reg.sum[war_pkg::SUM_W-1];
	assign sumMag = sumNeg ? (war_pkg::SUM_W)'(-s_reg.sum) : s_reg.sum;

	war_divider u_div (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.start     (s_reg.divStart),
		.dividend  (sumMag),
		.divisor   (s_reg.meanCnt),
		.done      (divDone),
		.quotient  (divQuot),
		.remainder (divRem)
	);

	// Floor toward minus infinity for negative sums
	assign floorQuot = divQuot
		+ (war_pkg::SUM_W)'(sumNeg && (divRem != '0));
	assign meanResult = sumNeg ? (war_pkg::SUM_W)'(-floorQuot) : floorQuot;

	assign packShift = {2'(war_pkg::NIB_PER_WORD - s_reg.packCnt), 2'b00};
	assign packWord  = {s_reg.packAcc, s_reg.holdWord[3:0]}
		<< packShift;

	// Reads and output units per operation; zero means nothing to do
	assign halfUp = {1'b0, elementCount} + (war_pkg::CNT_W+1)'(1);

	always_comb begin
		planReads = '0;
		planOuts  = '0;
		unique case (opSelect)
			war_pkg::OP_MEAN: begin
				if (elementCount != '0
					&& elementCount <= war_pkg::MEAN_MAX_COUNT) begin
					planReads = elementCount;
					planOuts  = elementCount;
				end
			end
			war_pkg::OP_WORD_TO_BYTE_SPLIT: begin
				planReads = halfUp[war_pkg::CNT_W:1];
				planOuts  = elementCount;
			end
			war_pkg::OP_BYTE_TO_WORD_COMBINE: begin
				planReads = elementCount;
				planOuts  = elementCount;
			end
			war_pkg::OP_NIBBLE_PACK: begin
				if (elementCount <= war_pkg::NIB_MAX_COUNT) begin
					planReads = elementCount;
					planOuts  = elementCount;
				end
			end
			war_pkg::OP_NIBBLE_SPLIT: begin
				if (elementCount != '0
					&& elementCount <= war_pkg::NIB_MAX_COUNT) begin
					planReads = (war_pkg::CNT_W)'(1);
					planOuts  = elementCount;
				end
			end
			default: begin
				planReads = '0;
				planOuts  = '0;
			end
		endcase
	end

	always_comb begin
		s_next = s_reg;
		s_next.opDone    = 1'b0;
		s_next.divStart  = 1'b0;
		s_next.memRdEn   = 1'b0;
		s_next.rdPending = s_reg.memRdEn;
		fifoPop = 1'b0;
		if (s_reg.memWrEn && memWrReady) begin
			s_next.memWrEn = 1'b0;
		end
		unique case (s_reg.st)
			ST_IDLE: begin
				if (enableCondition) begin
					s_next.op        = war_pkg::war_op_t'(opSelect);
					s_next.rdAddr    = sourceStart;
					s_next.wrAddr    = destStart;
					s_next.rdLeft    = planReads;
					s_next.outLeft   = planOuts;
					s_next.packCnt   = elementCount[2:0];
					s_next.meanCnt   = elementCount[war_pkg::MEAN_CNT_W-1:0];
					s_next.holdValid = 1'b0;
					s_next.phase     = 1'b0;
					s_next.sum       = war_pkg::SUM_RESET;
					s_next.packAcc   = war_pkg::PACK_RESET;
					s_next.st = (planOuts == '0) ? ST_FINISH : ST_RUN;
				end
			end
			ST_RUN: begin
				if (s_reg.rdLeft != '0 && roomOk) begin
					s_next.memRdEn   = 1'b1;
					s_next.memRdAddr = s_reg.rdAddr;
					s_next.rdAddr    = s_reg.rdAddr + war_pkg::ADDR_W'(1);
					s_next.rdLeft    = s_reg.rdLeft - war_pkg::CNT_W'(1);
				end
				if (!s_reg.holdValid) begin
					if (fifoOutValid) begin
						fifoPop          = 1'b1;
						s_next.holdWord  = fifoOutData;
						s_next.holdValid = 1'b1;
					end
				end else if (wrFree) begin
					s_next.outLeft = s_reg.outLeft - war_pkg::CNT_W'(1);
					unique case (s_reg.op)
						war_pkg::OP_MEAN: begin
							s_next.sum = s_reg.sum + (war_pkg::SUM_W)'(
								$signed(s_reg.holdWord));
							s_next.holdValid = 1'b0;
							if (s_reg.outLeft == war_pkg::CNT_W'(1)) begin
								s_next.divStart = 1'b1;
								s_next.st       = ST_DIV;
							end
						end
						war_pkg::OP_WORD_TO_BYTE_SPLIT: begin
							s_next.memWrEn   = 1'b1;
							s_next.memWrAddr = s_reg.wrAddr;
							s_next.memWrData = {war_pkg::BYTE_ZERO,
								s_reg.phase ? s_reg.holdWord[7:0]
									: s_reg.holdWord[15:8]};
							s_next.wrAddr = s_reg.wrAddr + war_pkg::ADDR_W'(1);
							s_next.phase  = !s_reg.phase;
							if (s_reg.phase
								|| s_reg.outLeft == war_pkg::CNT_W'(1)) begin
								s_next.holdValid = 1'b0;
							end
							if (s_reg.outLeft == war_pkg::CNT_W'(1)) begin
								s_next.st = ST_FINISH;
							end
						end
						war_pkg::OP_BYTE_TO_WORD_COMBINE: begin
							s_next.holdValid = 1'b0;
							if (!s_reg.phase) begin
								s_next.byteHi = s_reg.holdWord[7:0];
								s_next.phase  = 1'b1;
								if (s_reg.outLeft == war_pkg::CNT_W'(1)) begin
									s_next.memWrEn   = 1'b1;
									s_next.memWrAddr = s_reg.wrAddr;
									s_next.memWrData = {s_reg.holdWord[7:0],
										war_pkg::BYTE_ZERO};
									s_next.wrAddr = s_reg.wrAddr
										+ war_pkg::ADDR_W'(1);
									s_next.st = ST_FINISH;
								end
							end else begin
								s_next.memWrEn   = 1'b1;
								s_next.memWrAddr = s_reg.wrAddr;
								s_next.memWrData = {s_reg.byteHi,
									s_reg.holdWord[7:0]};
								s_next.wrAddr = s_reg.wrAddr + war_pkg::ADDR_W'(1);
								s_next.phase  = 1'b0;
								if (s_reg.outLeft == war_pkg::CNT_W'(1)) begin
									s_next.st = ST_FINISH;
								end
							end
						end
						war_pkg::OP_NIBBLE_PACK: begin
							s_next.holdValid = 1'b0;
							s_next.packAcc   = {s_reg.packAcc[7:0],
								s_reg.holdWord[3:0]};
							if (s_reg.outLeft == war_pkg::CNT_W'(1)) begin
								s_next.memWrEn   = 1'b1;
								s_next.memWrAddr = s_reg.wrAddr;
								s_next.memWrData = packWord;
								s_next.st        = ST_FINISH;
							end
						end
						war_pkg::OP_NIBBLE_SPLIT: begin
							s_next.memWrEn   = 1'b1;
							s_next.memWrAddr = s_reg.wrAddr;
							s_next.memWrData = {war_pkg::NIB_PAD_ZERO,
								s_reg.holdWord[15:12]};
							s_next.wrAddr   = s_reg.wrAddr + war_pkg::ADDR_W'(1);
							s_next.holdWord = {s_reg.holdWord[11:0],
								4'h0};
							if (s_reg.outLeft == war_pkg::CNT_W'(1)) begin
								s_next.holdValid = 1'b0;
								s_next.st        = ST_FINISH;
							end
						end
						default: begin
							s_next.holdValid = 1'b0;
							s_next.st        = ST_FINISH;
						end
					endcase
				end
			end
			ST_DIV: begin
				if (divDone) begin
					s_next.memWrEn   = 1'b1;
					s_next.memWrAddr = s_reg.wrAddr;
					s_next.memWrData =
						meanResult[war_pkg::DATA_W-1:0];
					s_next.st = ST_FINISH;
				end
			end
			ST_FINISH: begin
				// Done only once the last write has left the port
				if (wrFree) begin
					s_next.opDone = 1'b1;
					s_next.st     = ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end
endmodule // war_reshape_unit
